// file: include/i2c_host_port_pkg.sv
// Shared constants and types for the two-wire controller host port.
package i2c_host_port_pkg;

    // ---------------------------------------------------------------
    // Clocking and timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int STROBE_NS     = 32;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int SYNC_DEPTH    = 2;
    localparam int MASK_CYC      = STROBE_CYC + SYNC_DEPTH + 1;

    // ---------------------------------------------------------------
    // Control/status word layout and reset values
    // ---------------------------------------------------------------
    localparam int PIN_BIT = 7;
    localparam int ESO_BIT = 6;
    localparam int ES1_BIT = 5;
    localparam int ES2_BIT = 4;
    localparam int ENI_BIT = 3;
    localparam int STA_BIT = 2;
    localparam int STO_BIT = 1;
    localparam int ACK_BIT = 0;
    localparam logic       PIN_RST            = 1'b1;
    localparam logic [7:0] OWN_ADDR_RST       = 8'h00;
    localparam logic [7:0] CLOCK_RST          = 8'h00;
    localparam logic [7:0] VECTOR_RST_STROBE  = 8'h00;
    localparam logic [7:0] VECTOR_RST_DIR_ACK = 8'h0F;

    // Selection by {serial_out_enable, reg_sel_bit_one, reg_sel_bit_two}.
    localparam logic [2:0] SEL_OWN_ADDR = 3'h0;
    localparam logic [2:0] SEL_CLOCK    = 3'h2;
    localparam logic [2:0] SEL_VECTOR   = 3'h1;

    // Synchroniser lane layout and idle levels.
    localparam int               SYNC_W   = 16;
    localparam logic [SYNC_W-1:0] SYNC_RST = 16'hFF00;

    typedef struct packed {
        logic serial_out_enable;
        logic reg_sel_bit_one;
        logic reg_sel_bit_two;
        logic irq_enable_flag;
        logic start;
        logic stop;
        logic ack;
    } ctrl_t;

    typedef enum logic {MODE_STROBE, MODE_DIR_ACK} host_mode_t;
    typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} acc_state_t;

endpackage

// file: rtl/host_pin_sync.sv
// Two-stage synchroniser bank for the asynchronous host and bus pins.
`timescale 1ns/1ps
`default_nettype none
module host_pin_sync #(
    parameter int         W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // host_pin_sync
`default_nettype wire

// file: rtl/i2c_host_port.sv
// Parallel host port, interrupt, reset/strobe and serial pin muxing.
// Overview of operation
// - Outside long-distance mode, interrupt acknowledge with interrupts enabled drives the vector on data.
// - Outside long-distance mode, open-drain interrupt asserts when enabled and pending-not is clear.
// - Each completed serial byte clears the pending-not flag.
// - Select 1 picks control/status; 0 picks by control select bits.
// - Reset clears every flag but sets pending-not.
// - Reset pin is open-drain two-way and also drives a strobe.
// - Normally serial data and clock are open-drain two-way lines.
// - Long-distance mode uses four one-way serial lines.
// - Read pin is strobe input, or open-drain transfer acknowledge.
// - Eight-bit two-way data port, driven on reads, sampled on writes.
// - Strobe style by default; write fall without select switches style.
// - Vector defaults 00h, or 0Fh in acknowledge style.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_port
    import i2c_host_port_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       cs_n_i,
    input  wire logic       rd_n_i,
    output logic            rd_n_o,
    output logic            rd_oe_o,
    input  wire logic       wr_n_i,
    input  wire logic       reg_select_i,
    input  wire logic [7:0] host_data_i,
    output logic      [7:0] host_data_o,
    output logic            host_data_oe_o,
    input  wire logic       irq_ack_in_n_i,
    output logic            irq_n_o,
    output logic            irq_oe_o,
    input  wire logic       reset_strobe_n_i,
    output logic            reset_strobe_n_o,
    output logic            reset_strobe_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       long_dist_i,
    input  wire logic       sda_low_i,
    input  wire logic       scl_low_i,
    input  wire logic       byte_done_i,
    input  wire logic       strobe_req_i,
    input  wire logic [6:0] status_i,
    input  wire logic [7:0] rx_data_i,
    output ctrl_t           ctrl_o,
    output logic            pin_o,
    output logic      [7:0] own_addr_o,
    output logic      [7:0] clock_sel_o,
    output logic      [7:0] tx_data_o,
    output logic            tx_load_o,
    output logic            rx_taken_o,
    output logic            sda_in_o,
    output logic            scl_in_o,
    output logic            soft_rst_o
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] sync_s;
    logic              cs_n_s, rd_n_s, wr_n_s, a0_s;
    logic              irq_ack_in_n_s, rstp_n_s, sda_s, scl_s;
    logic [7:0]        data_s;

    host_pin_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .d_i    ({cs_n_i, rd_n_i, wr_n_i, reg_select_i, irq_ack_in_n_i,
                  reset_strobe_n_i, sda_i, scl_i, host_data_i}),
        .q_o    (sync_s)
    );
    assign {cs_n_s, rd_n_s, wr_n_s, a0_s, irq_ack_in_n_s,
            rstp_n_s, sda_s, scl_s, data_s} = sync_s;

    // ---------------------------------------------------------------
    // Reset pin: input reset and output strobe
    // ---------------------------------------------------------------
    logic [7:0] strobe_cnt_q;
    logic [7:0] mask_cnt_q;
    logic       soft_rst;

    // Our own strobe pulls the pin low; the mask outlasts the
    // synchroniser so the strobe never resets the controller itself.
    assign soft_rst = srst_i || (!rstp_n_s && mask_cnt_q == 8'h00);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            strobe_cnt_q <= 8'h00;
            mask_cnt_q   <= 8'h00;
        end else if (strobe_req_i) begin
            strobe_cnt_q <= 8'(STROBE_CYC);
            mask_cnt_q   <= 8'(MASK_CYC);
        end else begin
            if (strobe_cnt_q != 8'h00) strobe_cnt_q <= strobe_cnt_q - 8'h01;
            if (mask_cnt_q != 8'h00) mask_cnt_q <= mask_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reset_strobe_oe_o <= 1'b0;
            soft_rst_o        <= 1'b1;
        end else begin
            reset_strobe_oe_o <= strobe_req_i || strobe_cnt_q > 8'h01;
            soft_rst_o        <= soft_rst;
        end
    end
    assign reset_strobe_n_o = 1'b0;
    assign rd_n_o           = 1'b0;
    assign irq_n_o          = 1'b0;

    // ---------------------------------------------------------------
    // Interface style detection
    // ---------------------------------------------------------------
    host_mode_t mode_q;
    logic       wr_n_prev_q;
    logic       wr_fall;

    assign wr_fall = wr_n_prev_q && !wr_n_s;

    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            mode_q      <= MODE_STROBE;
            wr_n_prev_q <= 1'b1;
        end else begin
            wr_n_prev_q <= wr_n_s;
            if (wr_fall && cs_n_s) mode_q <= MODE_DIR_ACK;
        end
    end

    // ---------------------------------------------------------------
    // Access sequencing
    // ---------------------------------------------------------------
    acc_state_t acc_q;
    logic       a0_q;
    logic [7:0] wdata_q;
    logic       rd_req, wr_req, drive_rd, irq_ack_in_drive, commit;
    ctrl_t      ctrl_q;
    logic       pin_q;
    logic [2:0] sel;
    logic [7:0] vector_q;
    logic [7:0] rd_mux;

    // In acknowledge style the write pin carries direction, high = read.
    assign rd_req = !cs_n_s && ((mode_q == MODE_STROBE) ? !rd_n_s
                                                        : wr_n_s);
    assign wr_req = !cs_n_s && !wr_n_s;
    assign commit = (acc_q == ACC_WRITE) && !wr_req;
    assign drive_rd = rd_req && (acc_q != ACC_WRITE);
    assign irq_ack_in_drive = !irq_ack_in_n_s && ctrl_q.irq_enable_flag
                        && !long_dist_i;
    assign sel = {ctrl_q.serial_out_enable, ctrl_q.reg_sel_bit_one,
                  ctrl_q.reg_sel_bit_two};

    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            acc_q   <= ACC_IDLE;
            a0_q    <= 1'b0;
            wdata_q <= 8'h00;
        end else begin
            unique case (acc_q)
                ACC_IDLE: begin
                    a0_q <= a0_s;
                    if (rd_req) acc_q <= ACC_READ;
                    else if (wr_req) acc_q <= ACC_WRITE;
                end
                ACC_READ: begin
                    if (!rd_req) acc_q <= ACC_IDLE;
                end
                ACC_WRITE: begin
                    wdata_q <= data_s;
                    if (!wr_req) acc_q <= ACC_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers seen by the host
    // ---------------------------------------------------------------
    logic vec_written_q;

    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            ctrl_q        <= '0;
            own_addr_o    <= OWN_ADDR_RST;
            clock_sel_o   <= CLOCK_RST;
            vector_q      <= VECTOR_RST_STROBE;
            vec_written_q <= 1'b0;
        end else begin
            if (mode_q == MODE_STROBE && wr_fall && cs_n_s && !vec_written_q)
                vector_q <= VECTOR_RST_DIR_ACK;
            if (commit && a0_q) begin
                ctrl_q <= '{wdata_q[ESO_BIT], wdata_q[ES1_BIT],
                            wdata_q[ES2_BIT], wdata_q[ENI_BIT],
                            wdata_q[STA_BIT], wdata_q[STO_BIT],
                            wdata_q[ACK_BIT]};
            end else if (commit && !sel[2]) begin
                unique case (sel)
                    SEL_OWN_ADDR: own_addr_o <= wdata_q;
                    SEL_CLOCK:    clock_sel_o <= wdata_q;
                    SEL_VECTOR: begin
                        vector_q      <= wdata_q;
                        vec_written_q <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Data-register access re-arms the pending-not flag; a byte
    // finishing in the same cycle wins so the event is never lost.
    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            pin_q <= PIN_RST;
        end else if (byte_done_i) begin
            pin_q <= 1'b0;
        end else if (commit && a0_q && wdata_q[PIN_BIT]) begin
            pin_q <= 1'b1;
        end else if ((commit || (acc_q == ACC_READ && !rd_req))
                     && !a0_q && sel[2]) begin
            pin_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            tx_data_o  <= 8'h00;
            tx_load_o  <= 1'b0;
            rx_taken_o <= 1'b0;
        end else begin
            tx_load_o  <= commit && !a0_q && sel[2];
            rx_taken_o <= acc_q == ACC_READ && !rd_req && !a0_q && sel[2];
            if (commit && !a0_q && sel[2]) tx_data_o <= wdata_q;
        end
    end
    assign ctrl_o = ctrl_q;
    assign pin_o  = pin_q;

    // ---------------------------------------------------------------
    // Data port and transfer acknowledge
    // ---------------------------------------------------------------
    always_comb begin
        if (a0_s) begin
            rd_mux = {pin_q, status_i};
        end else if (sel[2]) begin
            rd_mux = rx_data_i;
        end else if (sel == SEL_OWN_ADDR) begin
            rd_mux = own_addr_o;
        end else if (sel == SEL_CLOCK) begin
            rd_mux = clock_sel_o;
        end else if (sel == SEL_VECTOR) begin
            rd_mux = vector_q;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            host_data_o    <= 8'h00;
            host_data_oe_o <= 1'b0;
            rd_oe_o        <= 1'b0;
        end else begin
            host_data_o    <= irq_ack_in_drive ? vector_q : rd_mux;
            host_data_oe_o <= drive_rd || irq_ack_in_drive;
            rd_oe_o        <= mode_q == MODE_DIR_ACK && acc_q != ACC_IDLE
                              && (rd_req || wr_req);
        end
    end

    // ---------------------------------------------------------------
    // Serial pins and interrupt pin
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (soft_rst) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_o    <= 1'b0;
            scl_oe_o <= 1'b0;
            irq_oe_o <= 1'b0;
            sda_in_o <= 1'b1;
            scl_in_o <= 1'b1;
        end else if (long_dist_i) begin
            sda_o    <= !sda_low_i;
            sda_oe_o <= 1'b1;
            scl_o    <= 1'b0;
            scl_oe_o <= 1'b0;
            irq_oe_o <= scl_low_i;
            sda_in_o <= irq_ack_in_n_s;
            scl_in_o <= scl_s;
        end else begin
            sda_o    <= 1'b0;
            sda_oe_o <= sda_low_i;
            scl_o    <= 1'b0;
            scl_oe_o <= scl_low_i;
            irq_oe_o <= ctrl_q.irq_enable_flag && !pin_q;
            sda_in_o <= sda_s;
            scl_in_o <= scl_s;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_irq_ack_in_vector;
        @(posedge mclk_i) disable iff (soft_rst)
        irq_ack_in_drive |=> host_data_oe_o && host_data_o == $past(vector_q);
    endproperty
    a_irq_ack_in_vector: assert property (p_irq_ack_in_vector)
        else $error("vector not driven during acknowledge");

    property p_irq;
        @(posedge mclk_i) disable iff (soft_rst)
        (!long_dist_i && ctrl_q.irq_enable_flag) |=>
            irq_oe_o == !$past(pin_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pin disagrees with pending flag");

    property p_byte_done;
        @(posedge mclk_i) disable iff (soft_rst)
        byte_done_i |=> !pin_q ##1 irq_oe_o || !ctrl_q.irq_enable_flag
                        || long_dist_i;
    endproperty
    a_byte_done: assert property (p_byte_done)
        else $error("completed byte did not clear pending flag");

    property p_sel_status;
        @(posedge mclk_i) disable iff (soft_rst)
        (drive_rd && a0_s && !irq_ack_in_drive) |=>
            host_data_o == {$past(pin_q), $past(status_i)};
    endproperty
    a_sel_status: assert property (p_sel_status)
        else $error("select high did not return control/status");

    property p_reset;
        @(posedge mclk_i)
        srst_i |=> pin_q && ctrl_q == '0 && mode_q == MODE_STROBE
                   && vector_q == VECTOR_RST_STROBE && !host_data_oe_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");

    property p_strobe;
        @(posedge mclk_i) disable iff (srst_i)
        strobe_req_i |=> reset_strobe_oe_o [*2] ##1 !soft_rst;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe not driven or caused a reset");

    property p_long_dist;
        @(posedge mclk_i) disable iff (soft_rst)
        long_dist_i |=> sda_oe_o && !scl_oe_o
                        && sda_o == !$past(sda_low_i);
    endproperty
    a_long_dist: assert property (p_long_dist)
        else $error("long-distance pin roles wrong");

    property p_transfer_ack_out;
        @(posedge mclk_i) disable iff (soft_rst)
        (mode_q == MODE_STROBE) |=> !rd_oe_o;
    endproperty
    a_transfer_ack_out: assert property (p_transfer_ack_out)
        else $error("acknowledge driven in strobe style");

    property p_mode;
        @(posedge mclk_i) disable iff (soft_rst)
        (mode_q == MODE_STROBE && wr_fall && cs_n_s) |=>
            mode_q == MODE_DIR_ACK;
    endproperty
    a_mode: assert property (p_mode)
        else $error("style switch missed");

    property p_hiz;
        @(posedge mclk_i) disable iff (soft_rst)
        (!drive_rd && !irq_ack_in_drive) |=> !host_data_oe_o;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("data port driven outside a read");

endmodule // i2c_host_port
`default_nettype wire

// file: verification/host_cpu_model.sv
// Host processor model that drives the controller's parallel port.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input  wire logic       mclk_i,
    input  wire logic       transfer_ack_out_i,
    input  wire logic [7:0] data_i,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            sel_o,
    output logic      [7:0] data_o,
    output logic            data_en_o,
    output logic            irq_ack_in_n_o
);
    logic ack_style = 1'b0;

    initial begin
        cs_n_o    = 1'b1;
        rd_n_o    = 1'b1;
        wr_n_o    = 1'b1;
        sel_o     = 1'b1;
        data_o    = 8'h00;
        data_en_o = 1'b0;
        irq_ack_in_n_o  = 1'b1;
    end

    // One register access; the strobe style holds six cycles, the
    // acknowledge style waits for the acknowledge under a bound.
    task automatic access(input logic wr, input logic sel,
                          input logic [7:0] wd, output logic [7:0] rdat);
        int n;
        @(negedge mclk_i);
        sel_o     = sel;
        data_o    = wd;
        data_en_o = wr;
        cs_n_o    = 1'b0;
        if (ack_style) wr_n_o = !wr;
        else if (wr) wr_n_o = 1'b0;
        else rd_n_o = 1'b0;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack_style ? (!transfer_ack_out_i && n < 30) : n < 6);
        rdat = data_i;
        if (ack_style && !transfer_ack_out_i) rdat = 'x;
        @(negedge mclk_i);
        cs_n_o    = 1'b1;
        rd_n_o    = 1'b1;
        wr_n_o    = 1'b1;
        data_en_o = 1'b0;
        repeat (8) @(negedge mclk_i);
    endtask

    // A write-pin fall with the chip deselected picks the other style.
    task automatic to_ack_style();
        @(negedge mclk_i);
        wr_n_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        wr_n_o    = 1'b1;
        ack_style = 1'b1;
        repeat (6) @(negedge mclk_i);
    endtask
endmodule // host_cpu_model
`default_nettype wire

// file: verification/i2c_host_port_tb.sv
// Self-checking testbench for the controller host port.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_port_tb;
    import i2c_host_port_pkg::*;
    typedef struct {logic [7:0] ctl; logic [7:0] wd; logic [7:0] exp;} row_t;
    logic mclk_i = 1'b0, srst_i, byte_done_i, strobe_req_i, long_dist_i;
    logic sda_low_i, scl_low_i, rst_pin, h_cs_n, h_rd_n, h_wr_n, h_sel;
    logic h_en, h_irq_ack_in_n, rd_n_o, rd_oe_o, host_data_oe_o, irq_n_o, irq_oe_o;
    logic rst_o, rst_oe, sda_o, sda_oe_o, scl_o, scl_oe_o, pin_o, tx_load_o;
    logic rx_taken_o, sda_in_o, scl_in_o, soft_rst_o;
    logic [6:0] status_i = 7'h2A;
    logic [7:0] rx_data_i = 8'hC3, h_dq, host_data_o, own_addr_o, clock_sel_o;
    logic [7:0] tx_data_o, rd;
    ctrl_t ctrl_o;
    int fail_count = 0, check_count = 0, n;
    int tx_loads = 0, rx_takes = 0;
    row_t rows[4] = '{'{8'h00, 8'h55, 8'h55}, '{8'h20, 8'h1C, 8'h1C},
                      '{8'h10, 8'hA5, 8'hA5}, '{8'h30, 8'h77, 8'h00}};
    // A released bus shows the inverse of the last value, not a hold.
    wire [7:0] bus = host_data_oe_o ? host_data_o : h_en ? h_dq : ~h_dq;
    wire rd_w = rd_oe_o ? rd_n_o : h_rd_n;
    wire rs_w = (rst_oe ? rst_o : 1'b1) & rst_pin;

    always #2 mclk_i = ~mclk_i;

    // One-cycle pulses are counted where they are settled.
    always @(negedge mclk_i) begin
        tx_loads += int'(tx_load_o);
        rx_takes += int'(rx_taken_o);
    end

    host_cpu_model i_host (.mclk_i(mclk_i), .transfer_ack_out_i(rd_oe_o), .data_i(bus),
        .cs_n_o(h_cs_n), .rd_n_o(h_rd_n), .wr_n_o(h_wr_n), .sel_o(h_sel),
        .data_o(h_dq), .data_en_o(h_en), .irq_ack_in_n_o(h_irq_ack_in_n));

    i2c_host_port i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(h_cs_n),
        .rd_n_i(rd_w), .rd_n_o(rd_n_o), .rd_oe_o(rd_oe_o), .wr_n_i(h_wr_n),
        .reg_select_i(h_sel), .host_data_i(bus), .host_data_o(host_data_o),
        .host_data_oe_o(host_data_oe_o), .irq_ack_in_n_i(h_irq_ack_in_n),
        .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .reset_strobe_n_i(rs_w),
        .reset_strobe_n_o(rst_o), .reset_strobe_oe_o(rst_oe),
        .sda_i(sda_oe_o ? sda_o : 1'b1), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .scl_i(scl_oe_o ? scl_o : 1'b1), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .long_dist_i(long_dist_i), .sda_low_i(sda_low_i),
        .scl_low_i(scl_low_i), .byte_done_i(byte_done_i),
        .strobe_req_i(strobe_req_i), .status_i(status_i),
        .rx_data_i(rx_data_i), .ctrl_o(ctrl_o), .pin_o(pin_o),
        .own_addr_o(own_addr_o), .clock_sel_o(clock_sel_o),
        .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
        .rx_taken_o(rx_taken_o), .sda_in_o(sda_in_o), .scl_in_o(scl_in_o),
        .soft_rst_o(soft_rst_o));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic pulse_byte_done();
        @(negedge mclk_i);
        byte_done_i = 1'b1;
        @(negedge mclk_i);
        byte_done_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask

    task automatic irq_ack_in_check(input logic [7:0] oe_exp, input logic [7:0] v);
        i_host.irq_ack_in_n_o = 1'b0;
        repeat (5) @(negedge mclk_i);
        check("vec_oe", host_data_oe_o, oe_exp);
        if (oe_exp[0]) check("vec", host_data_o, v);
        i_host.irq_ack_in_n_o = 1'b1;
        repeat (5) @(negedge mclk_i);
        check("irq_ack_in_oe", host_data_oe_o, 8'h00);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {srst_i, rst_pin} = 2'b11;
        {byte_done_i, strobe_req_i, long_dist_i} = 3'b000;
        {sda_low_i, scl_low_i} = 2'b00;
        repeat (8) @(negedge mclk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        check("pin", pin_o, 8'h01);
        check("ctrl", {1'b0, ctrl_o}, 8'h00);
        check("oes", {rd_oe_o, host_data_oe_o, irq_oe_o, rst_oe}, 8'h00);
        i_host.access(1'b0, 1'b1, 8'h00, rd);
        check("status", rd, {1'b1, status_i});
        i_host.access(1'b1, 1'b1, 8'h10, rd);
        i_host.access(1'b0, 1'b0, 8'h00, rd);
        check("vec_rst", rd, VECTOR_RST_STROBE);
        foreach (rows[i]) begin
            i_host.access(1'b1, 1'b1, rows[i].ctl, rd);
            check("ctrl", {1'b0, ctrl_o}, {1'b0, rows[i].ctl[6:0]});
            i_host.access(1'b1, 1'b0, rows[i].wd, rd);
            i_host.access(1'b0, 1'b0, 8'h00, rd);
            check("reg", rd, rows[i].exp);
        end
        check("own", own_addr_o, 8'h55);
        check("clk", clock_sel_o, 8'h1C);
        i_host.access(1'b1, 1'b1, 8'h40, rd);
        i_host.access(1'b1, 1'b0, 8'h3C, rd);
        check("tx", tx_data_o, 8'h3C);
        i_host.access(1'b0, 1'b0, 8'h00, rd);
        check("rx", rd, rx_data_i);
        check("pulses", {tx_loads[3:0], rx_takes[3:0]}, 8'h11);
        // Interrupt raised, acknowledged, released by set and by disable.
        i_host.access(1'b1, 1'b1, 8'h18, rd);
        pulse_byte_done();
        check("pin_clr", pin_o, 8'h00);
        check("irq", {irq_oe_o, irq_n_o}, 8'h02);
        irq_ack_in_check(8'h01, 8'hA5);
        i_host.access(1'b1, 1'b1, 8'h98, rd);
        check("irq_set", {pin_o, irq_oe_o}, 8'h02);
        pulse_byte_done();
        i_host.access(1'b1, 1'b1, 8'h10, rd);
        check("irq_dis", irq_oe_o, 8'h00);
        irq_ack_in_check(8'h00, 8'h00);
        // Strobe on the reset pin must not reset the controller itself.
        @(negedge mclk_i);
        strobe_req_i = 1'b1;
        n = 0;
        repeat (20) begin
            @(negedge mclk_i);
            strobe_req_i = 1'b0;
            n += int'(rst_oe === 1'b1);
        end
        check("strobe", 8'(n), 8'(STROBE_CYC));
        check("no_rst", {rst_o, pin_o}, 8'h00);
        @(negedge mclk_i);
        rst_pin = 1'b0;
        repeat (5) @(negedge mclk_i);
        check("soft", soft_rst_o, 8'h01);
        rst_pin = 1'b1;
        i_host.ack_style = 1'b0;
        repeat (6) @(negedge mclk_i);
        check("pin_rst", {pin_o, ctrl_o}, 8'h80);
        // Acknowledge style after reset gives its own default vector.
        i_host.to_ack_style();
        i_host.access(1'b1, 1'b1, 8'h10, rd);
        i_host.access(1'b0, 1'b0, 8'h00, rd);
        check("vec_ack", rd, VECTOR_RST_DIR_ACK);
        // Serial pins, normal then long-distance.
        sda_low_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        check("sda", {sda_oe_o, sda_o, sda_in_o}, 8'h04);
        {sda_low_i, scl_low_i} = 2'b01;
        repeat (4) @(negedge mclk_i);
        check("scl", {scl_oe_o, scl_o, scl_in_o}, 8'h04);
        {long_dist_i, scl_low_i} = 2'b10;
        i_host.irq_ack_in_n_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        check("ld_sda", {sda_oe_o, sda_o, sda_in_o}, 8'h06);
        check("ld_scl", {scl_oe_o, irq_oe_o}, 8'h00);
        scl_low_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        check("ld_clk", irq_oe_o, 8'h01);
        results();
    end

    initial begin
        #40000;
        fail_count++;
        results();
    end
endmodule // i2c_host_port_tb
`default_nettype wire
